// ### include/buck_regulator_control_regs.svh
// Register offsets, field positions and reset values of the step-down converter control bank
`ifndef BUCK_REGULATOR_CONTROL_REGS_SVH
`define BUCK_REGULATOR_CONTROL_REGS_SVH

// Register offsets on the serial register port
`define VOLTAGE_SETTING_OFS 8'h30
`define MODE_CONTROL_OFS 8'h31
`define RESERVED_READONLY_OFS 8'h32
`define ENABLE_AND_STATUS_OFS 8'h33

// Field positions in voltage_setting
`define CODE_MSB 5
`define CODE_LSB 0
`define RANGE_BIT 6

// Field positions in mode_control
`define FORCED_PWM_BIT 0

// Field positions in enable_and_status
`define ENABLE_BIT 0
`define POWER_GOOD_BIT 1
`define WRITE_EXACT_BIT 2

// Reset values of the writable fields
`define CODE_RST 6'h00
`define RANGE_RST 1'h1
`define FORCED_PWM_RST 1'h0
`define ENABLE_RST 1'h0
`define WRITE_EXACT_RST 1'h0

// Value returned by read-only bits
`define RO_BYTE_RST 8'h00

// Stages of the pin synchronisers
`define SYNC_STAGES 2

// Upper range decode: base and step in millivolts
`define UPPER_BASE_MV 13'h04E2
`define UPPER_STEP_MV 13'h0032

`endif

// ### include/buck_regulator_control_pkg.sv
// Types shared by the step-down converter control bank
package buck_regulator_control_pkg;

  // One register byte
  typedef logic [7:0] reg_byte_t;

  // Millivolt value of the decoded target
  typedef logic [12:0] millivolt_t;

  // Which register an address selects
  typedef enum logic [2:0] {
    SEL_VOLTAGE,
    SEL_MODE,
    SEL_RESERVED,
    SEL_STATUS,
    SEL_NONE
  } reg_sel_e;

endpackage

// ### core/output_voltage_decoder.sv
// Decodes range select and output voltage code into a target voltage in millivolts
`timescale 1ns/10ps
`include "buck_regulator_control_regs.svh"

module output_voltage_decoder
  import buck_regulator_control_pkg::*;
(
  // Programmed setting
  input wire logic [5:0] output_voltage_code_i,
  input wire logic voltage_range_select_i,
  // Decoded target
  output millivolt_t target_mv_o,
  output logic code_unavailable_o
);

  // Lower range table; the steps are uneven, so a table beats arithmetic
  always_comb
  begin
    target_mv_o = '0;
    code_unavailable_o = 1'b0;
    if (voltage_range_select_i)
    begin
      // Upper range is a clean 50 mV ladder from the base
      target_mv_o = `UPPER_BASE_MV + 13'(`UPPER_STEP_MV * 13'(output_voltage_code_i));
    end
    else
    begin
      unique case (output_voltage_code_i)
        6'h12: target_mv_o = 13'd1100; // Lower range, column 01
        6'h13: target_mv_o = 13'd1125;
        6'h14: target_mv_o = 13'd1150;
        6'h15: target_mv_o = 13'd1175;
        6'h16: target_mv_o = 13'd1200;
        6'h17: target_mv_o = 13'd1225;
        6'h18: target_mv_o = 13'd1255;
        6'h19: target_mv_o = 13'd1280;
        6'h1A: target_mv_o = 13'd1305;
        6'h1B: target_mv_o = 13'd1330;
        6'h1C: target_mv_o = 13'd1355;
        6'h1D: target_mv_o = 13'd1380;
        6'h1E: target_mv_o = 13'd1405;
        6'h1F: target_mv_o = 13'd1430;
        6'h20: target_mv_o = 13'd1455; // Column 10
        6'h21: target_mv_o = 13'd1480;
        6'h22: target_mv_o = 13'd1505;
        6'h23: target_mv_o = 13'd1530;
        6'h24: target_mv_o = 13'd1555;
        6'h25: target_mv_o = 13'd1585;
        6'h26: target_mv_o = 13'd1610;
        6'h27: target_mv_o = 13'd1635;
        6'h28: target_mv_o = 13'd1660;
        6'h29: target_mv_o = 13'd1685;
        6'h2A: target_mv_o = 13'd1710;
        6'h2B: target_mv_o = 13'd1735;
        6'h2C: target_mv_o = 13'd1760;
        6'h2D: target_mv_o = 13'd1785;
        6'h2E: target_mv_o = 13'd1810;
        6'h2F: target_mv_o = 13'd1835;
        6'h30: target_mv_o = 13'd1860; // Column 11
        6'h31: target_mv_o = 13'd1890;
        6'h32: target_mv_o = 13'd1915;
        6'h33: target_mv_o = 13'd1940;
        6'h34: target_mv_o = 13'd1965;
        6'h35: target_mv_o = 13'd1990;
        6'h36: target_mv_o = 13'd2015;
        6'h37: target_mv_o = 13'd2040;
        6'h38: target_mv_o = 13'd2065;
        6'h39: target_mv_o = 13'd2090;
        6'h3A: target_mv_o = 13'd2115;
        6'h3B: target_mv_o = 13'd2140;
        6'h3C: target_mv_o = 13'd2165;
        6'h3D: target_mv_o = 13'd2190;
        6'h3E: target_mv_o = 13'd2200;
        6'h3F: target_mv_o = 13'd2245;
        // Column 00 and first two rows of 01 have no voltage
        default: code_unavailable_o = 1'b1;
      endcase
    end
  end

endmodule

// ### core/buck_regulator_control_regs.sv
// Control and status register bank of the third step-down converter
//
// Overview of operation
// - Six-bit voltage code, read/write, at 0x30
// - Bit 6 of 0x30 selects range
// - Target voltage decoded from range and code
// - Fixed layout of registers 0x30 to 0x33
// - Mode bit forces PWM; enable bit and pin run
// - Read-only bits ignore writes, read fixed value
// - Runs only with enable pin and bit
// - Power-good reads low below threshold
// - Mode one forces fixed-frequency over load
`timescale 1ns/10ps
`include "buck_regulator_control_regs.svh"

module buck_regulator_control_regs
  import buck_regulator_control_pkg::*;
#(
  parameter reg_byte_t RO_VALUE = `RO_BYTE_RST // Value read-only bits return
)
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register port from the two-wire serial interface engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output reg_byte_t reg_rdata_o,
  output logic reg_rvalid_o,
  // Converter core controls
  output logic [5:0] output_voltage_code_o,
  output logic voltage_range_select_o,
  output logic forced_pwm_o,
  output logic enable_bit_o,
  output logic converter_run_o,
  output millivolt_t target_mv_o,
  output logic code_unavailable_o,
  // Pins and analog status
  input wire logic converter_enable_pin_i,
  input wire logic power_good_i
);

  // Address decode; used by both the write and read paths
  function automatic reg_sel_e decode_addr(input logic [7:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    unique case (addr)
      `VOLTAGE_SETTING_OFS: sel = SEL_VOLTAGE;
      `MODE_CONTROL_OFS: sel = SEL_MODE;
      `RESERVED_READONLY_OFS: sel = SEL_RESERVED;
      `ENABLE_AND_STATUS_OFS: sel = SEL_STATUS;
      default: sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // Synchroniser chains for the two asynchronous inputs
  logic [`SYNC_STAGES-1:0] pin_sync_ff; // Enable pin chain
  logic [`SYNC_STAGES-1:0] pgood_sync_ff; // Power-good chain
  logic [`SYNC_STAGES-1:0] nxt_pin_sync;
  logic [`SYNC_STAGES-1:0] nxt_pgood_sync;

  // Writable fields
  logic [5:0] code_ff; // Output voltage code
  logic range_ff; // Range select
  logic forced_pwm_ff; // Mode select
  logic enable_ff; // Enable bit
  logic write_exact_ff; // Write-exact bit, stored as written
  logic [5:0] nxt_code;
  logic nxt_range;
  logic nxt_forced_pwm;
  logic nxt_enable;
  logic nxt_write_exact;

  // Read path and registered core outputs
  reg_byte_t rdata_ff;
  reg_byte_t nxt_rdata;
  logic rvalid_ff;
  logic nxt_rvalid;
  logic run_ff;
  logic nxt_run;
  millivolt_t target_mv_ff;
  millivolt_t nxt_target_mv;
  logic unavailable_ff;
  logic nxt_unavailable;

  // Decoder output, combinational
  millivolt_t dec_mv;
  logic dec_unavailable;
  reg_sel_e wr_sel;
  reg_sel_e rd_sel;

  // Decode the current setting; the result is registered below
  output_voltage_decoder u_decoder (
    .output_voltage_code_i(code_ff),
    .voltage_range_select_i(range_ff),
    .target_mv_o(dec_mv),
    .code_unavailable_o(dec_unavailable)
  );

  // Synchronisers: only the last stage is ever read by logic
  always_comb
  begin
    nxt_pin_sync = {pin_sync_ff[`SYNC_STAGES-2:0], converter_enable_pin_i};
    nxt_pgood_sync = {pgood_sync_ff[`SYNC_STAGES-2:0], power_good_i};
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pin_sync_ff <= '0;
      pgood_sync_ff <= '0;
    end
    else
    begin
      pin_sync_ff <= nxt_pin_sync;
      pgood_sync_ff <= nxt_pgood_sync;
    end
  end

  // Write path: only writable bits take the data, all else ignores it
  always_comb
  begin
    wr_sel = decode_addr(reg_addr_i);
    nxt_code = code_ff;
    nxt_range = range_ff;
    nxt_forced_pwm = forced_pwm_ff;
    nxt_enable = enable_ff;
    nxt_write_exact = write_exact_ff;
    if (reg_wr_i)
    begin
      unique case (wr_sel)
        SEL_VOLTAGE:
        begin
          // Bit 7 is read-only and drops the written value
          nxt_code = reg_wdata_i[`CODE_MSB:`CODE_LSB];
          nxt_range = reg_wdata_i[`RANGE_BIT];
        end
        SEL_MODE:
        begin
          nxt_forced_pwm = reg_wdata_i[`FORCED_PWM_BIT];
        end
        SEL_STATUS:
        begin
          nxt_enable = reg_wdata_i[`ENABLE_BIT];
          // Stored verbatim; no check, software must write the default
          nxt_write_exact = reg_wdata_i[`WRITE_EXACT_BIT];
        end
        // Reserved and unmapped addresses absorb writes silently
        SEL_RESERVED, SEL_NONE:
        begin
          nxt_code = code_ff;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      code_ff <= `CODE_RST;
      range_ff <= `RANGE_RST;
      forced_pwm_ff <= `FORCED_PWM_RST;
      enable_ff <= `ENABLE_RST;
      write_exact_ff <= `WRITE_EXACT_RST;
    end
    else
    begin
      code_ff <= nxt_code;
      range_ff <= nxt_range;
      forced_pwm_ff <= nxt_forced_pwm;
      enable_ff <= nxt_enable;
      write_exact_ff <= nxt_write_exact;
    end
  end

  // Read path: data is registered so it holds steady for the serial shifter
  always_comb
  begin
    rd_sel = decode_addr(reg_addr_i);
    nxt_rdata = rdata_ff;
    nxt_rvalid = reg_rd_i;
    if (reg_rd_i)
    begin
      nxt_rdata = RO_VALUE; // Read-only bits keep the fixed value
      unique case (rd_sel)
        SEL_VOLTAGE:
        begin
          nxt_rdata[`CODE_MSB:`CODE_LSB] = code_ff;
          nxt_rdata[`RANGE_BIT] = range_ff;
        end
        SEL_MODE:
        begin
          nxt_rdata[`FORCED_PWM_BIT] = forced_pwm_ff;
        end
        SEL_STATUS:
        begin
          nxt_rdata[`ENABLE_BIT] = enable_ff;
          nxt_rdata[`POWER_GOOD_BIT] = pgood_sync_ff[`SYNC_STAGES-1];
          nxt_rdata[`WRITE_EXACT_BIT] = write_exact_ff;
        end
        SEL_RESERVED:
        begin
          nxt_rdata = RO_VALUE; // Whole byte read-only
        end
        SEL_NONE:
        begin
          nxt_rdata = '0; // Unmapped addresses read as zero
        end
      endcase
    end
  end

  // Core-facing outputs, registered one cycle after the state changes
  always_comb
  begin
    // Both the synchronised pin and the bit must be high to run
    nxt_run = pin_sync_ff[`SYNC_STAGES-1] & enable_ff;
    nxt_target_mv = dec_mv;
    nxt_unavailable = dec_unavailable;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
      run_ff <= 1'b0;
      target_mv_ff <= '0;
      unavailable_ff <= 1'b0;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      run_ff <= nxt_run;
      target_mv_ff <= nxt_target_mv;
      unavailable_ff <= nxt_unavailable;
    end
  end

  // Field registers drive the core directly, no extra delay
  assign output_voltage_code_o = code_ff;
  assign voltage_range_select_o = range_ff;
  assign forced_pwm_o = forced_pwm_ff;
  assign enable_bit_o = enable_ff;
  assign converter_run_o = run_ff;
  assign target_mv_o = target_mv_ff;
  assign code_unavailable_o = unavailable_ff;
  assign reg_rdata_o = rdata_ff;
  assign reg_rvalid_o = rvalid_ff;

endmodule

// ### dv/buck_regulator_control_checker.sv
// Concurrent checks on the register bank ports
`timescale 1ns/10ps
`include "buck_regulator_control_regs.svh"
module buck_regulator_control_checker
  import buck_regulator_control_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire reg_byte_t reg_rdata_o,
  input wire logic reg_rvalid_o,
  // Converter controls
  input wire logic [5:0] output_voltage_code_o,
  input wire logic voltage_range_select_o,
  input wire logic forced_pwm_o,
  input wire logic enable_bit_o,
  input wire millivolt_t target_mv_o,
  input wire logic code_unavailable_o,
  input wire logic converter_run_o,
  // Pins and analog status
  input wire logic converter_enable_pin_i,
  input wire logic power_good_i
);
  // Single domain, so one clock and one disable serve all
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Read answer comes exactly one cycle after the strobe
  property p_rvalid; reg_rvalid_o |-> $past(reg_rd_i); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid without strobe");
  property p_rd_ans; reg_rd_i |=> reg_rvalid_o; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read strobe not answered");
  property p_output_voltage_code;
    reg_wr_i && reg_addr_i == 8'h30 |=> {voltage_range_select_o, output_voltage_code_o} == $past(reg_wdata_i[6:0]);
  endproperty
  a_output_voltage_code: assert property (p_output_voltage_code) else $error("voltage setting write lost");
  property p_mode; reg_wr_i && reg_addr_i == 8'h31 |=> forced_pwm_o == $past(reg_wdata_i[0]); endproperty
  a_mode: assert property (p_mode) else $error("mode write lost");
  property p_en; reg_wr_i && reg_addr_i == 8'h33 |=> enable_bit_o == $past(reg_wdata_i[0]); endproperty
  a_en: assert property (p_en) else $error("enable write lost");
  // Code only moves on a write to its own register
  property p_hold; !(reg_wr_i && reg_addr_i == 8'h30) |=> $stable(output_voltage_code_o); endproperty
  a_hold: assert property (p_hold) else $error("code changed without write");
  property p_rd_en; reg_rd_i && reg_addr_i == 8'h33 |=> reg_rdata_o[0] == $past(enable_bit_o); endproperty
  a_rd_en: assert property (p_rd_en) else $error("enable readback wrong");
  property p_upper;
    voltage_range_select_o |=> target_mv_o == `UPPER_BASE_MV + `UPPER_STEP_MV * {7'h00, $past(output_voltage_code_o)};
  endproperty
  a_upper: assert property (p_upper) else $error("upper range target wrong");
  property p_na; !voltage_range_select_o && output_voltage_code_o[5:4] == 2'h0 |=> code_unavailable_o; endproperty
  a_na: assert property (p_na) else $error("unavailable code not flagged");
  // Every available lower range code gives a real target and no flag
  property p_lower_ok;
    !voltage_range_select_o && output_voltage_code_o[5:4] != 2'h0 && output_voltage_code_o[5:1] != 5'h08
      |=> !code_unavailable_o && target_mv_o != 13'h0000;
  endproperty
  a_lower_ok: assert property (p_lower_ok) else $error("available code flagged or zero");
  // Run needs the bit one edge back and the pin three edges back, through the synchroniser
  property p_run; converter_run_o |-> $past(enable_bit_o) && $past(converter_enable_pin_i, 3); endproperty
  a_run: assert property (p_run) else $error("converter runs without pin and bit");
  // Power-good readback lags the pin by the synchroniser plus the read cycle
  property p_pgood; reg_rd_i && reg_addr_i == 8'h33 |=> reg_rdata_o[1] == $past(power_good_i, 3); endproperty
  a_pgood: assert property (p_pgood) else $error("power-good readback wrong");
endmodule

// ### dv/host_model.sv
// Behavioural system processor issuing single-byte register transfers
`timescale 1ns/10ps
module host_model
(
  // Clock
  input wire logic sys_clk_i,
  // Register port
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // Idle bus at time zero
  initial
  begin
    reg_addr_o = 8'hA5;
    reg_wdata_o = 8'h5A;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One-cycle write strobe; released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
  // One-cycle read strobe, answer awaited for a few cycles only
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    for (int n = 0; n < 3; n++)
    begin
      if (!ok && reg_rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        d = reg_rdata_i;
      end
      if (!ok) @(negedge sys_clk_i);
    end
  endtask
endmodule

// ### dv/buck_regulator_control_regs_tb.sv
// Self-checking bench for the converter control register bank
`timescale 1ns/10ps
module buck_regulator_control_regs_tb
  import buck_regulator_control_pkg::*;
;
  // Row: address, data, writable mask, expected target, unavailable flag
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] m; logic [12:0] mv; logic na;} row_s;
  logic sys_clk_i = 1'b0, arst_n_i = 1'b0, pin = 1'b0, pgood = 1'b0;
  logic [7:0] addr, wdata, rdata, rb;
  logic wr, rd, rvalid, pwm, en, run, range, na;
  logic [5:0] code;
  millivolt_t tmv;
  int err_total = 0, n_compared = 0;
  // Only available codes are programmed; write-exact bit kept at its default 0
  row_s rows [0:9] = '{'{8'h30, 8'h45, 8'h7F, 13'h05DC, 1'b0}, '{8'h30, 8'h7F, 8'h7F, 13'h1130, 1'b0},
    '{8'h30, 8'h32, 8'h7F, 13'h077B, 1'b0}, '{8'h30, 8'h12, 8'h7F, 13'h044C, 1'b0},
    '{8'h30, 8'h20, 8'h7F, 13'h05AF, 1'b0}, '{8'h30, 8'h13, 8'h7F, 13'h0465, 1'b0},
    '{8'h31, 8'h01, 8'h01, 13'h0000, 1'b0}, '{8'h31, 8'h00, 8'h01, 13'h0000, 1'b0},
    '{8'h33, 8'h01, 8'h05, 13'h0000, 1'b0}, '{8'h33, 8'h00, 8'h05, 13'h0000, 1'b0}};
  // Free-running 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;
  buck_regulator_control_regs dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .output_voltage_code_o(code),
    .voltage_range_select_o(range), .forced_pwm_o(pwm), .enable_bit_o(en), .converter_run_o(run),
    .target_mv_o(tmv), .code_unavailable_o(na), .converter_enable_pin_i(pin), .power_good_i(pgood));
  host_model host (.sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd),
    .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
  // Counted comparison, four-state exact
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Read that gives up on a silent bank
  task automatic rdc(input logic [7:0] a);
    bit ok;
    host.rd(a, rb, ok);
    if (!ok)
    begin
      err_total++;
      tally_and_finish();
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // Main sequence
  initial
  begin
    wait_n(10);
    arst_n_i = 1'b1;
    wait_n(2);
    check("reset fields", {7'h00, code, range, pwm, en}, 16'h0004);
    check("reset target", {3'h0, tmv}, 16'h04E2);
    foreach (rows[i])
    begin
      host.wr(rows[i].a, rows[i].d);
      rdc(rows[i].a);
      check("readback", {8'h00, rb & rows[i].m}, {8'h00, rows[i].d & rows[i].m});
      if (rows[i].a == 8'h30) check("target", {2'h0, na, tmv}, {2'h0, rows[i].na, rows[i].mv});
      if (rows[i].a == 8'h31) check("mode", {15'h0000, pwm}, {15'h0000, rows[i].d[0]});
      if (rows[i].a == 8'h33) check("enable", {15'h0000, en}, {15'h0000, rows[i].d[0]});
    end
    // Read-only places ignore writes
    host.wr(8'h31, 8'hFE);
    host.wr(8'h32, 8'hFF);
    wait_n(2);
    check("ro write", {8'h00, code, range, pwm}, 16'h004C);
    rdc(8'h40);
    check("unmapped", {8'h00, rb}, 16'h0000);
    // Pin alone does not run the converter
    pin = 1'b1;
    pgood = 1'b1;
    wait_n(5);
    check("run bit off", {15'h0000, run}, 16'h0000);
    host.wr(8'h33, 8'h01);
    wait_n(4);
    check("run", {15'h0000, run}, 16'h0001);
    rdc(8'h33);
    check("pgood high", {15'h0000, rb[1]}, 16'h0001);
    pin = 1'b0;
    pgood = 1'b0;
    wait_n(5);
    check("run pin off", {15'h0000, run}, 16'h0000);
    rdc(8'h33);
    check("pgood low", {15'h0000, rb[1]}, 16'h0000);
    // Reset in mid-run returns every field and core output to its reset value
    pin = 1'b1;
    wait_n(5);
    check("run before reset", {15'h0000, run}, 16'h0001);
    arst_n_i = 1'b0;
    wait_n(1);
    check("fields in reset", {7'h00, code, range, pwm, en}, 16'h0004);
    check("core in reset", {1'b0, run, na, tmv}, 16'h0000);
    wait_n(9);
    arst_n_i = 1'b1;
    wait_n(2);
    check("target after reset", {3'h0, tmv}, 16'h04E2);
    check("run after reset", {15'h0000, run}, 16'h0000);
    rdc(8'h30);
    check("voltage after reset", {8'h00, rb & 8'h7F}, 16'h0040);
    tally_and_finish();
  end
endmodule
bind buck_regulator_control_regs buck_regulator_control_checker chk (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .output_voltage_code_o(output_voltage_code_o),
  .voltage_range_select_o(voltage_range_select_o), .forced_pwm_o(forced_pwm_o), .enable_bit_o(enable_bit_o),
  .target_mv_o(target_mv_o), .code_unavailable_o(code_unavailable_o), .converter_run_o(converter_run_o),
  .converter_enable_pin_i(converter_enable_pin_i), .power_good_i(power_good_i));
